// ===== include/cric_pkg.sv
// Constants and types shared by the clock, reset and interrupt block
package cric_pkg;
    // Register byte addresses and reset values
    localparam logic [7:0] MISC_ADDR = 8'h20;
    localparam logic [7:0] STAT_ADDR = 8'h24;
    localparam logic [7:0] MISC_RESET = 8'h00;
    // Miscellaneous register fields
    localparam int MISC_SLOW_BIT = 0;
    localparam int MISC_DIV_LSB = 1;
    localparam int MISC_POL01_LSB = 3;
    localparam int MISC_CLKOUT_BIT = 5;
    localparam int MISC_POL23_LSB = 6;
    // Status register fields
    localparam int STAT_WAIT_BIT = 0;
    localparam int STAT_HALT_BIT = 1;
    localparam int STAT_RESET_BIT = 2;
    localparam int STAT_MASK_BIT = 3;
    localparam int STAT_PEND_LSB = 4;
    // Interrupt sources
    localparam int N_EXT = 4;
    localparam int N_PER = 5;
    localparam int N_SRC = 9;
    localparam int EXT_PINS = 4;
    localparam int VEC_W = 16;
    localparam logic [15:0] RESET_VEC = 16'hFFFE;
    localparam logic [15:0] TRAP_VEC = 16'hFFFC;
    localparam logic [15:0] SRC_VEC [N_SRC] = '{16'hFFF6, 16'hFFF4,
        16'hFFF2, 16'hFFF0, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6,
        16'hFFE4};
    localparam logic [8:0] HALT_WAKE = 9'h00F;
    // Timing
    localparam int CLK_FREQ_MHZ = 250;
    localparam int DRIVE_TIME_NS = 1000;
    localparam int DRIVE_CYCLES = (DRIVE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int STAB_CORE_CYCLES = 4096;
    // External interrupt sensitivity codes
    typedef enum logic [1:0]
    {
        POL_FALL_LOW = 2'h0,
        POL_RISE = 2'h1,
        POL_FALL = 2'h2,
        POL_BOTH = 2'h3
    } cric_pol_type;
    // Sequencer states
    typedef enum logic [2:0]
    {
        ST_DRIVE, ST_HOLD, ST_STAB, ST_RUN, ST_PUSH, ST_WAIT, ST_HALT, ST_WAKE
    } cric_state_type;
endpackage

// ===== rtl/cric_clkdiv.sv
// Processor clock divider with equal high and low phases
`timescale 1ns/1ps
module cric_clkdiv
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Divider control
    input wire logic run,
    input wire logic slow,
    input wire logic [1:0] div_sel,
    // Generated clock
    output logic clk_out,
    output logic tick
);
    import cric_pkg::*;

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] half_m1;
    logic clk_q;
    logic clk_d;
    logic tick_q;
    logic tick_d;
    logic wrap;

    // Half period minus one, in oscillator cycles
    assign half_m1 = slow ? 4'((5'h02 << div_sel) - 5'h01) : 4'h0; // [RULE1]
    assign wrap = cnt_q >= half_m1;
    assign cnt_d = (!run || wrap) ? 4'h0 : cnt_q + 4'h1;
    assign clk_d = run && (wrap ? !clk_q : clk_q); // [RULE2]
    assign tick_d = run && wrap && !clk_q;
    assign clk_out = clk_q;
    assign tick = tick_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_q <= 4'h0;
            clk_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
            tick_q <= tick_d;
        end
    end

    // Judged only once the divide setting has stood for two cycles
    a_equal_phase: assert property (@(posedge clk) // [RULE2]
        disable iff (!rst_b) ($changed(clk_q) && $past(run)
        && $stable(half_m1) && $past(half_m1, 2) == half_m1)
        |-> $past(cnt_q) == half_m1)
        else $error("clock phase length wrong");
endmodule

// ===== rtl/cric_extint.sv
// Edge and level detector for one shared external interrupt vector
`timescale 1ns/1ps
module cric_extint
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Synchronised pins and their interrupt enables
    input wire logic [cric_pkg::EXT_PINS-1:0] pins,
    input wire logic [cric_pkg::EXT_PINS-1:0] pin_ie,
    // Sensitivity and latch clear
    input wire logic [1:0] pol,
    input wire logic clr,
    // Request
    output logic req
);
    import cric_pkg::*;

    logic any_ie;
    logic comb;
    logic prev_q;
    logic latch_q;
    logic latch_d;
    logic fall_en;
    logic rise_en;
    logic hit;

    assign any_ie = |pin_ie;
    // Pins not enabled read as high in the AND
    assign comb = &(pins | ~pin_ie); // [RULE19]
    assign fall_en = pol != POL_RISE; // [RULE25]
    assign rise_en = (pol == POL_RISE) || (pol == POL_BOTH);
    assign hit = any_ie && ((fall_en && prev_q && !comb)
        || (rise_en && !prev_q && comb));
    // A new edge wins over a clear in the same cycle
    assign latch_d = hit || (latch_q && !clr); // [RULE18]
    assign req = latch_q || (pol == POL_FALL_LOW && any_ie && !comb);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            prev_q <= 1'b1;
            latch_q <= 1'b0;
        end
        else
        begin
            prev_q <= comb;
            latch_q <= latch_d;
        end
    end

    a_clear_latch: assert property (@(posedge clk) // [RULE18]
        disable iff (!rst_b) (clr && !hit) |=> !latch_q)
        else $error("edge latch not cleared");
    a_and_masks: assert property (@(posedge clk) // [RULE19]
        disable iff (!rst_b)
        (pol == POL_RISE && |(pin_ie & ~pins) && !latch_q) |=> !latch_q)
        else $error("low pin failed to mask request");
endmodule

// ===== rtl/cric_top.sv
// Clock, reset sequencing and interrupt control of the core
// Functional notes
// [RULE1] Core clock is oscillator/2, slow adds /2..16
// [RULE2] Core clock has equal high and low phases
// [RULE3] Reset from pin, power-on, watchdog, low voltage
// [RULE4] Reset exit loads vector FFFEh
// [RULE5] Internal reset drives reset pin low fixed time
// [RULE6] Reset lasts at least 4096 core cycles
// [RULE7] Pin reset captured asynchronously, any clock state
// [RULE8] Reset held while pin stays low
// [RULE9] 4096-cycle delay after reset and halt wake
// [RULE10] Low voltage holds reset and pin low
// [RULE11] Maskable requests wait while mask set
// [RULE12] Entry stacks context, sets mask, loads vector
// [RULE13] Return from interrupt clears mask
// [RULE14] Highest fixed priority request served first
// [RULE15] Trap entered regardless of mask
// [RULE16] Any wakes wait; external only wakes halt
// [RULE17] External vector needs event and clear mask
// [RULE18] Edge request latched, cleared on entry
// [RULE19] Shared-vector pins ANDed before detection
// [RULE20] Peripheral request needs enable and clear mask
// [RULE21] Peripheral clears request by flag sequence
// [RULE22] Clear sequence discards pending latch
// [RULE23] Mask set means maskables disabled
// [RULE24] Wait clears mask and stops the core
// [RULE25] Polarity resets to falling edge and low
// [RULE26] Reset released synchronously to clock
`timescale 1ns/1ps
module cric_top
#(
    parameter int STAB_CYCLES = cric_pkg::STAB_CORE_CYCLES
)
(
    // Clock and power-on reset
    input wire logic CLK,
    input wire logic RST_B,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Reset pin and reset sources
    input wire logic RST_B_PIN_IN,
    output logic RST_B_PIN_OUT,
    output logic RST_B_PIN_OE,
    input wire logic WDG_RST,
    input wire logic LVD_LOW,
    output logic SYS_RESET_B,
    // Generated clocks
    output logic CORE_CLK_OUT,
    output logic CORE_CLK_EN,
    output logic PERIPH_CLK_EN,
    // External interrupt pins
    input wire logic [15:0] EXT_PIN_IN,
    input wire logic [15:0] EXT_PIN_IE,
    // Peripheral interrupt flags
    input wire logic [cric_pkg::N_PER-1:0] PERIPH_FLAG,
    input wire logic [cric_pkg::N_PER-1:0] PERIPH_EN,
    input wire logic [cric_pkg::N_PER-1:0] PERIPH_CLR,
    // Core handshake
    input wire logic INSTR_END,
    input wire logic TRAP_EXEC,
    input wire logic RETURN_FROM_INTERRUPT_EXEC,
    input wire logic SIM_EXEC,
    input wire logic RIM_EXEC,
    input wire logic WFI_EXEC,
    input wire logic HALT_EXEC,
    input wire logic STACK_DONE,
    output logic INT_ENTRY,
    output logic VEC_LOAD,
    output logic [cric_pkg::VEC_W-1:0] VECTOR,
    output logic MASK_BIT
);
    import cric_pkg::*;

    function automatic logic is_reg(input logic [31:0] a,
        input logic [7:0] off);
        return a == {24'h000000, off};
    endfunction

    function automatic logic [15:0] vec_of(input logic [N_SRC-1:0] oh);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < N_SRC; i++)
            if (oh[i])
                v = v | SRC_VEC[i];
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic rpin_a_q;
    logic rpin_b_q;
    logic [16:0] sync_a_q;
    logic [16:0] sync_b_q;
    logic pin_low;
    logic lvd_s;
    logic [15:0] ext_s;

    // Asserts with the pin, releases on the clock
    always_ff @(posedge CLK or negedge RST_B_PIN_IN) // [RULE7]
    begin
        if (!RST_B_PIN_IN)
        begin
            rpin_a_q <= 1'b0;
            rpin_b_q <= 1'b0;
        end
        else
        begin
            rpin_a_q <= 1'b1;
            rpin_b_q <= rpin_a_q; // [RULE26]
        end
    end

    always_ff @(posedge CLK)
    begin
        sync_a_q <= {LVD_LOW, EXT_PIN_IN};
        sync_b_q <= sync_a_q;
    end

    assign pin_low = !rpin_b_q;
    assign lvd_s = sync_b_q[16];
    assign ext_s = sync_b_q[15:0];

    ////////////////////////////////////////////////////////////////////
    // Register bus

    logic [7:0] misc_q;
    logic [7:0] misc_d;
    logic wr_misc_q;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic [31:0] stat;
    logic ap_valid;
    logic ap_word;
    logic wr_misc;
    logic [N_EXT-1:0] pol_chg;

    assign ap_valid = HSEL && HTRANS[1] && HREADY;
    assign ap_word = HSIZE == 3'h2;
    assign wr_misc = wr_misc_q;
    assign misc_d = wr_misc ? HWDATA[7:0] : misc_q;
    // Any change of a polarity field drops the latched requests of both vectors it controls
    assign pol_chg[0] = wr_misc && (HWDATA[4:3] != misc_q[4:3]);
    assign pol_chg[1] = pol_chg[0];
    assign pol_chg[2] = wr_misc && (HWDATA[7:6] != misc_q[7:6]);
    assign pol_chg[3] = pol_chg[2];
    // Reads see a write still in its data phase
    assign hrdata_d = !(ap_valid && !HWRITE) ? 32'h00000000 :
        is_reg(HADDR, MISC_ADDR) ? {24'h000000, misc_d} :
        is_reg(HADDR, STAT_ADDR) ? stat : 32'h00000000;

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            misc_q <= MISC_RESET; // [RULE25]
            wr_misc_q <= 1'b0;
            hrdata_q <= 32'h00000000;
        end
        else
        begin
            misc_q <= misc_d;
            wr_misc_q <= ap_valid && HWRITE && ap_word
                && is_reg(HADDR, MISC_ADDR);
            hrdata_q <= hrdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock divider

    logic div_clk;
    logic div_tick;
    cric_state_type state_q;
    cric_state_type state_d;

    cric_clkdiv u_div
    (
        .clk(CLK),
        .rst_b(RST_B),
        .run(state_q != ST_HALT),
        .slow(misc_q[MISC_SLOW_BIT]),
        .div_sel(misc_q[MISC_DIV_LSB +: 2]),
        .clk_out(div_clk),
        .tick(div_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Interrupt requests

    logic [N_EXT-1:0] ext_req;
    logic [N_EXT-1:0] ext_clr;
    logic [N_PER-1:0] per_prev_q;
    logic [N_PER-1:0] per_pend_q;
    logic [N_PER-1:0] per_pend_d;
    logic [N_SRC-1:0] pend;
    logic [N_SRC-1:0] mreq;
    logic [N_SRC-1:0] sel_oh;
    logic [N_SRC-1:0] src_oh_q;
    logic trap_pend_q;
    logic entry_any;
    logic halt_any;
    logic mask_q;
    logic vec_go;

    genvar g;
    generate
        for (g = 0; g < N_EXT; g++)
        begin : g_ext
            cric_extint u_ext
            (
                .clk(CLK),
                .rst_b(RST_B),
                .pins(ext_s[g*EXT_PINS +: EXT_PINS]),
                .pin_ie(EXT_PIN_IE[g*EXT_PINS +: EXT_PINS]),
                .pol(g < 2 ? misc_q[MISC_POL01_LSB +: 2]
                    : misc_q[MISC_POL23_LSB +: 2]),
                .clr(ext_clr[g]),
                .req(ext_req[g])
            );
        end
    endgenerate

    // Edge latches are dropped as their routine is entered
    assign ext_clr = (vec_go ? src_oh_q[N_EXT-1:0] : 4'h0) | pol_chg; // [RULE18]
    // Flag edge latches; set wins over a clearing sequence
    assign per_pend_d = (PERIPH_FLAG & ~per_prev_q)
        | (per_pend_q & ~PERIPH_CLR); // [RULE21] [RULE22]
    assign pend = {per_pend_q & PERIPH_EN, ext_req}; // [RULE20]
    assign mreq = mask_q ? 9'h000 : pend; // [RULE11] [RULE17] [RULE23]
    assign sel_oh = mreq & (~mreq + 9'h001); // [RULE14]
    assign entry_any = trap_pend_q || (|mreq); // [RULE15]
    assign halt_any = |(mreq & HALT_WAKE);

    ////////////////////////////////////////////////////////////////////
    // Reset, power and entry sequencer

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic int_rst;
    logic drive_done;
    logic stab_done;
    logic entry_cap;
    logic rst_vec_go;
    logic in_rst_d;
    logic sleep_go;
    logic mask_d;

    assign int_rst = WDG_RST || lvd_s; // [RULE3] [RULE10]
    assign drive_done = cnt_q == 16'(DRIVE_CYCLES - 1);
    assign stab_done = div_tick && cnt_q == 16'(STAB_CYCLES - 1);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_DRIVE:
                if (drive_done)
                    state_d = ST_HOLD;
            ST_HOLD:
                if (!pin_low)
                    state_d = ST_STAB; // [RULE8]
            ST_STAB:
                if (stab_done)
                    state_d = ST_RUN; // [RULE6]
            ST_RUN:
                if (INSTR_END && entry_any)
                    state_d = ST_PUSH; // [RULE12]
                else if (WFI_EXEC)
                    state_d = ST_WAIT;
                else if (HALT_EXEC)
                    state_d = ST_HALT;
            ST_PUSH:
                if (STACK_DONE)
                    state_d = ST_RUN;
            ST_WAIT:
                if (|mreq)
                    state_d = ST_PUSH; // [RULE16]
            ST_HALT:
                if (halt_any)
                    state_d = ST_WAKE; // [RULE16]
            ST_WAKE:
                if (stab_done)
                    state_d = entry_any ? ST_PUSH : ST_RUN; // [RULE9]
            default:
                state_d = ST_DRIVE;
        endcase
        if (int_rst)
            state_d = ST_DRIVE; // [RULE3]
        else if (pin_low && state_q != ST_DRIVE)
            state_d = ST_HOLD; // [RULE7]
    end

    // Counter restarts on every state change; low voltage pins it at zero
    assign cnt_d = (state_d != state_q || int_rst) ? 16'h0000 :
        (state_q == ST_DRIVE || div_tick) ? cnt_q + 16'h0001 : cnt_q;
    assign entry_cap = state_d == ST_PUSH && state_q != ST_PUSH;
    assign vec_go = state_q == ST_PUSH && state_d == ST_RUN;
    assign rst_vec_go = state_q == ST_STAB && state_d == ST_RUN; // [RULE4]
    assign in_rst_d = state_d == ST_DRIVE || state_d == ST_HOLD
        || state_d == ST_STAB;
    assign sleep_go = state_q == ST_RUN
        && (state_d == ST_WAIT || state_d == ST_HALT); // [RULE24]
    // Mask set by reset, entry or software; cleared by return, software or sleep
    assign mask_d = (in_rst_d || vec_go || (SIM_EXEC && state_q == ST_RUN))
        ? 1'b1 : ((RETURN_FROM_INTERRUPT_EXEC || RIM_EXEC) && state_q == ST_RUN)
        || sleep_go ? 1'b0 : mask_q; // [RULE12] [RULE13] [RULE24]

    assign stat = {19'h00000, pend, mask_q, state_q == ST_DRIVE
        || state_q == ST_HOLD || state_q == ST_STAB, state_q == ST_HALT
        || state_q == ST_WAKE, state_q == ST_WAIT};

    ////////////////////////////////////////////////////////////////////
    // State and output registers

    logic sys_rst_b_q;
    logic pin_oe_q;
    logic core_en_q;
    logic per_en_q;
    logic core_clk_q;
    logic int_entry_q;
    logic vec_load_q;
    logic [15:0] vector_q;
    logic core_run;

    assign core_run = !(state_q == ST_WAIT || state_q == ST_HALT
        || state_q == ST_WAKE); // [RULE24]

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            state_q <= ST_DRIVE;
            cnt_q <= 16'h0000;
            mask_q <= 1'b1;
            trap_pend_q <= 1'b0;
            src_oh_q <= 9'h000;
            per_prev_q <= 5'h00;
            per_pend_q <= 5'h00;
            sys_rst_b_q <= 1'b0;
            pin_oe_q <= 1'b1;
            core_en_q <= 1'b0;
            per_en_q <= 1'b0;
            core_clk_q <= 1'b0;
            int_entry_q <= 1'b0;
            vec_load_q <= 1'b0;
            vector_q <= RESET_VEC;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            mask_q <= mask_d;
            trap_pend_q <= in_rst_d ? 1'b0 : TRAP_EXEC
                || (trap_pend_q && !entry_cap); // [RULE15]
            if (entry_cap)
                src_oh_q <= trap_pend_q ? 9'h000 : sel_oh;
            per_prev_q <= PERIPH_FLAG;
            per_pend_q <= in_rst_d ? 5'h00 : per_pend_d;
            sys_rst_b_q <= !in_rst_d; // [RULE6]
            pin_oe_q <= state_d == ST_DRIVE; // [RULE5] [RULE10]
            core_en_q <= div_tick && core_run; // [RULE1]
            per_en_q <= div_tick && state_q != ST_HALT; // [RULE1]
            core_clk_q <= div_clk;
            int_entry_q <= state_d == ST_PUSH;
            vec_load_q <= vec_go || rst_vec_go;
            if (rst_vec_go)
                vector_q <= RESET_VEC; // [RULE4]
            else if (entry_cap)
                vector_q <= trap_pend_q ? TRAP_VEC : vec_of(sel_oh); // [RULE14]
        end
    end

    assign HRDATA = hrdata_q;
    assign HREADYOUT = 1'b1 | sys_rst_b_q;
    assign HRESP = 1'b0 & sys_rst_b_q;
    assign RST_B_PIN_OUT = 1'b0 & pin_oe_q;
    assign RST_B_PIN_OE = pin_oe_q;
    assign SYS_RESET_B = sys_rst_b_q;
    assign CORE_CLK_OUT = core_clk_q;
    assign CORE_CLK_EN = core_en_q;
    assign PERIPH_CLK_EN = per_en_q;
    assign INT_ENTRY = int_entry_q;
    assign VEC_LOAD = vec_load_q;
    assign VECTOR = vector_q;
    assign MASK_BIT = mask_q;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    a_reset_vector: assert property (rst_vec_go // [RULE4]
        |=> VEC_LOAD && VECTOR == RESET_VEC && SYS_RESET_B)
        else $error("reset vector not loaded");
    a_pin_drive: assert property ($rose(RST_B_PIN_OE) // [RULE5]
        |-> RST_B_PIN_OE [*8])
        else $error("reset pin drive too short");
    a_stab_length: assert property (rst_vec_go // [RULE6]
        |-> cnt_q == 16'(STAB_CYCLES - 1) && div_tick)
        else $error("stabilisation count wrong");
    a_pin_hold: assert property ((state_q == ST_HOLD && pin_low) // [RULE8]
        |=> !SYS_RESET_B)
        else $error("left reset with pin low");
    a_lvd_hold: assert property (lvd_s // [RULE10]
        |=> RST_B_PIN_OE && !SYS_RESET_B)
        else $error("low voltage did not hold reset");
    a_masked_wait: assert property ((state_q == ST_RUN && mask_q // [RULE11]
        && !trap_pend_q) |=> state_q != ST_PUSH)
        else $error("masked request entered");
    a_entry_mask: assert property (vec_go // [RULE12]
        |=> VEC_LOAD && MASK_BIT && !INT_ENTRY)
        else $error("entry did not set mask");
    a_return_clear: assert property ((state_q == ST_RUN // [RULE13]
        && state_d == ST_RUN && RETURN_FROM_INTERRUPT_EXEC && !SIM_EXEC) |=> !MASK_BIT)
        else $error("return left mask set");
    a_prio_pick: assert property ((entry_cap && !trap_pend_q // [RULE14]
        && mreq[0]) |=> VECTOR == SRC_VEC[0])
        else $error("wrong priority vector");
    a_trap_entry: assert property ((state_q == ST_RUN && INSTR_END // [RULE15]
        && trap_pend_q && !int_rst && !pin_low)
        |=> INT_ENTRY ##0 (state_q == ST_PUSH))
        else $error("trap not entered");
    a_halt_stay: assert property ((state_q == ST_HALT // [RULE16]
        && !halt_any && !int_rst && !pin_low) |=> state_q == ST_HALT)
        else $error("halt left without wake source");
    a_wait_mask: assert property ((state_q == ST_RUN && state_d == ST_WAIT) // [RULE24]
        |=> !MASK_BIT ##1 !CORE_CLK_EN)
        else $error("wait entry wrong");

    c_reset_vector: cover property (rst_vec_go);
    c_trap_entry: cover property (entry_cap && trap_pend_q);
    c_wait_wake: cover property (state_q == ST_WAIT && state_d == ST_PUSH);
    c_halt_wake: cover property (state_q == ST_WAKE && state_d == ST_PUSH);
endmodule

// ===== verif/cric_core_model.sv
// Behavioural core: ends instructions and stacks context on entry
`timescale 1ns/1ps
module cric_core_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Entry handshake
    input wire logic int_entry,
    output logic instr_end = 1'b0,
    output logic stack_done = 1'b0
);
    int seed = 7;
    int wait_cnt = 0;
    always @(posedge clk)
    begin
        instr_end <= 1'b0;
        stack_done <= 1'b0;
        if (rst_b !== 1'b1)
            wait_cnt <= 0;
        else if (int_entry && !stack_done)
        begin
            // Stacking takes a random time, prompt or slow
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= ($random(seed) & 7))
            begin
                stack_done <= 1'b1;
                wait_cnt <= 0;
            end
        end
        else
            instr_end <= ($random(seed) % 2) != 0;
    end
endmodule

// ===== verif/cric_top_tb.sv
// Self-checking bench of the clock, reset and interrupt block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cric_top_tb;
    import cric_pkg::*;
    logic CLK = 1'b0;
    logic RST_B, HSEL, HWRITE, WDG_RST, LVD_LOW, ext_rst_b, TRAP_EXEC;
    logic RETURN_FROM_INTERRUPT_EXEC, SIM_EXEC, RIM_EXEC, WFI_EXEC, HALT_EXEC;
    logic HREADYOUT, HRESP, RST_B_PIN_OE, SYS_RESET_B, CORE_CLK_EN;
    logic INSTR_END, STACK_DONE, INT_ENTRY, VEC_LOAD, MASK_BIT;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [31:0] HADDR, HWDATA, HRDATA, rd, wd;
    logic [15:0] EXT_PIN_IN, EXT_PIN_IE, VECTOR, v;
    logic [4:0] PERIPH_FLAG, PERIPH_EN, PERIPH_CLR, pat;
    int fail_count = 0, n_checks = 0, seed = 34, idx, n, ocnt;
    // Open-drain reset pin with pull-up
    wire rst_pin = ~RST_B_PIN_OE & ext_rst_b;
    always #2 CLK = ~CLK;
    cric_top #(.STAB_CYCLES(8)) u_cric_top (.CLK, .RST_B, .HSEL, .HADDR,
        .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA,
        .HREADYOUT, .HRESP, .RST_B_PIN_IN(rst_pin), .RST_B_PIN_OUT(),
        .RST_B_PIN_OE, .WDG_RST, .LVD_LOW, .SYS_RESET_B, .CORE_CLK_OUT(),
        .CORE_CLK_EN, .PERIPH_CLK_EN(), .EXT_PIN_IN, .EXT_PIN_IE,
        .PERIPH_FLAG, .PERIPH_EN, .PERIPH_CLR, .INSTR_END, .TRAP_EXEC,
        .RETURN_FROM_INTERRUPT_EXEC, .SIM_EXEC, .RIM_EXEC, .WFI_EXEC, .HALT_EXEC,
        .STACK_DONE, .INT_ENTRY, .VEC_LOAD, .VECTOR, .MASK_BIT);
    cric_core_model u_cric_core_model (.clk(CLK), .rst_b(SYS_RESET_B),
        .int_entry(INT_ENTRY), .instr_end(INSTR_END),
        .stack_done(STACK_DONE));
    ////////////////////////////////////////////////////////////////////
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task return_from_interrupt;
        RETURN_FROM_INTERRUPT_EXEC <= 1'b1;
        @(posedge CLK);
        RETURN_FROM_INTERRUPT_EXEC <= 1'b0;
    endtask
    // Waits for a vector load, counts reset-pin drive cycles on the way
    task wvec(input logic [15:0] e);
        v = 16'h0;
        ocnt = 0;
        for (n = 0; n < 3000 && v == 16'h0; n++)
        begin
            @(negedge CLK);
            ocnt += RST_B_PIN_OE;
            if (VEC_LOAD === 1'b1)
                v = VECTOR;
        end
        `CHK(v, e)
        @(posedge CLK);
    endtask
    task per(input int e);
        repeat (40) @(posedge CLK);
        @(posedge CORE_CLK_EN);
        @(negedge CLK);
        n = 0;
        do begin @(negedge CLK); n++; end while (CORE_CLK_EN !== 1'b1);
        `CHK(n, e)
        @(posedge CLK);
    endtask
    task end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {RST_B, HSEL, HWRITE, WDG_RST, LVD_LOW, TRAP_EXEC} = '0;
        {RETURN_FROM_INTERRUPT_EXEC, SIM_EXEC, RIM_EXEC, WFI_EXEC, HALT_EXEC} = '0;
        {HADDR, HWDATA, HTRANS, PERIPH_FLAG, PERIPH_CLR} = '0;
        ext_rst_b = 1'b1;
        HSIZE = 3'h2;
        EXT_PIN_IN = 16'hFFFF;
        EXT_PIN_IE = 16'h000F;
        PERIPH_EN = 5'h1F;
        repeat (4) @(posedge CLK);
        RST_B <= 1'b1;
        wvec(RESET_VEC);
        `CHK(ocnt >= DRIVE_CYCLES, 1'b1)
        bus(1'b0, 32'h40, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, MISC_ADDR, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, STAT_ADDR, 32'h0);
        `CHK(rd[STAT_MASK_BIT], 1'b1)
        wd = $random(seed);
        bus(1'b1, MISC_ADDR, wd);
        bus(1'b0, MISC_ADDR, 32'h0);
        `CHK(rd, {24'h0, wd[7:0]})
        for (idx = 0; idx < 4; idx++)
        begin
            bus(1'b1, MISC_ADDR, {idx[1:0], 1'b1});
            per(4 << idx);
        end
        bus(1'b1, MISC_ADDR, 32'h0);
        per(2);
        TRAP_EXEC <= 1'b1;
        @(posedge CLK);
        TRAP_EXEC <= 1'b0;
        wvec(TRAP_VEC);
        pat = $random(seed) | 5'h10;
        PERIPH_FLAG <= pat;
        repeat (20) @(negedge CLK);
        `CHK(INT_ENTRY, 1'b0)
        @(posedge CLK);
        while (pat != 5'h0)
        begin
            idx = 0;
            while (!pat[idx])
                idx++;
            return_from_interrupt;
            @(negedge CLK);
            `CHK(MASK_BIT, 1'b0)
            @(posedge CLK);
            wvec(SRC_VEC[N_EXT + idx]);
            `CHK(MASK_BIT, 1'b1)
            pat[idx] = 1'b0;
            PERIPH_CLR[idx] <= 1'b1;
            PERIPH_FLAG <= pat;
            @(posedge CLK);
            PERIPH_CLR <= 5'h0;
        end
        // Rising-edge mode; a low pin in the group hides the edge
        bus(1'b1, MISC_ADDR, 32'h08);
        EXT_PIN_IN[1] <= 1'b0;
        return_from_interrupt;
        EXT_PIN_IN[0] <= 1'b0;
        repeat (8) @(posedge CLK);
        EXT_PIN_IN[0] <= 1'b1;
        repeat (8) @(negedge CLK);
        `CHK(INT_ENTRY, 1'b0)
        @(posedge CLK);
        EXT_PIN_IN[1] <= 1'b1;
        wvec(SRC_VEC[0]);
        // Wait wakes on a peripheral, halt only on an external edge
        for (idx = 0; idx < 2; idx++)
        begin
            WFI_EXEC <= idx == 0;
            HALT_EXEC <= idx == 1;
            @(posedge CLK);
            {WFI_EXEC, HALT_EXEC, PERIPH_CLR[0]} <= 3'h0;
            PERIPH_FLAG[0] <= 1'b1;
            @(negedge CLK);
            `CHK(MASK_BIT, 1'b0)
            @(posedge CLK);
            if (idx == 1)
            begin
                repeat (30) @(negedge CLK);
                `CHK(INT_ENTRY, 1'b0)
                @(posedge CLK);
                EXT_PIN_IN[0] <= 1'b0;
                repeat (4) @(posedge CLK);
                EXT_PIN_IN[0] <= 1'b1;
            end
            wvec(SRC_VEC[idx == 0 ? N_EXT : 0]);
            PERIPH_FLAG[0] <= 1'b0;
            PERIPH_CLR[0] <= 1'b1;
        end
        @(posedge CLK);
        PERIPH_CLR <= 5'h0;
        for (idx = 0; idx < 3; idx++)
        begin
            WDG_RST <= idx == 0;
            LVD_LOW <= idx == 1;
            ext_rst_b <= idx != 2;
            repeat (200) @(negedge CLK);
            `CHK(SYS_RESET_B, 1'b0)
            `CHK(RST_B_PIN_OE, idx != 2)
            @(posedge CLK);
            {WDG_RST, LVD_LOW, ext_rst_b} <= 3'h1;
            wvec(RESET_VEC);
        end
        end_sim;
    end
    initial
    begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        end_sim;
    end
endmodule
